// ### design/mrr_pkg.sv
/*
  Constants for the main converter round-robin sequencer and result registers.
  Assumes a 10 MHz system clock and a plain register port on the same clock.

// Summary of operation
// - 24 slots measured in repeating round robin
// - each slot 8 us, pass 192 us
// - slots: die, bias ref, cells, bar, pin, spares
// - results 16-bit two's complement, high/low bytes
// - converter enable presets all pairs to 0x8000
// - pair updated when its slot completes
// - high read freezes low until low read
// - main and auxiliary converters enabled independently
// - die sensor code zero means zero degrees
// - bias reference off at reset, enable bit only
// - all eight pin inputs within 1.6 ms
// - align cell start, cells within 128 us
// - measure only in full-power mode
// - one pin input per pass, rotating
// - inactive cell slot kept, not measured
*/
`default_nettype none
package mrr_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ = 10000000;
  localparam int SLOT_NS = 8000;
  localparam int SLOT_CYC = SLOT_NS / (1000000000 / CLK_HZ);
  localparam int NUM_SLOTS = 24;
  localparam int NUM_CELLS = 16;
  localparam int NUM_PINS = 8;
  // ************************************************************
  // slot map
  // ************************************************************
  localparam logic [4:0] SLOT_DIE = 5'h00;
  localparam logic [4:0] SLOT_BIAS = 5'h01;
  localparam logic [4:0] SLOT_CELL0 = 5'h02;
  localparam logic [4:0] SLOT_BAR = 5'h12;
  localparam logic [4:0] SLOT_PIN = 5'h13;
  localparam logic [4:0] SLOT_LAST = 5'h17;
  // result index: 0 die,1 bias,2..17 cells,18 bar,19..26 pins
  localparam int NUM_RES = 27;
  localparam logic [4:0] RES_PIN0 = 5'h13;
  localparam logic [15:0] RESULT_PRESET = 16'h8000;
  // ************************************************************
  // register map (word index)
  // ************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h01;
  localparam logic [7:0] REG_RES_BASE = 8'h10;
  localparam int CTRL_MAIN_EN = 0;
  localparam int CTRL_AUX_EN = 1;
  localparam int CTRL_BIAS_EN = 2;
  localparam int CTRL_FULL_PWR = 3;
  localparam int CTRL_TOP_LSB = 4;
  localparam logic [3:0] TOP_RESET = 4'hf;
  typedef enum logic [1:0] {
    MRR_IDLE = 2'b01,
    MRR_RUN = 2'b10
  } mrr_state_t;
endpackage : mrr_pkg
`default_nettype wire

// ### design/mrr_main_adc.sv
/*
  Round-robin sequencer and result register pairs of the main converter.
  Assumes the analog sample arrives on adcSample from
  logic on clk_sys; syncIn is a pin and is synchronised here.
*/
`default_nettype none
module mrr_main_adc (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic syncIn,
  input wire logic [15:0] adcSample,
  output logic [4:0] muxSel,
  output logic [2:0] pinSel,
  output logic convStart,
  output logic mainEnable,
  output logic auxEnable,
  output logic biasRefEnable
);
  import mrr_pkg::*;

  // ************************************************************
  // control register
  // ************************************************************
  logic [7:0] ctrl_reg;
  logic [1:0] syncPipe_reg;
  logic syncPrev_reg;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= {TOP_RESET, 4'h0};
    end else if (regWr && regAddr == REG_CTRL) begin
      ctrl_reg <= regWdata;
    end
  end
  logic [3:0] topActive;
  logic runOk;
  assign topActive = ctrl_reg[CTRL_TOP_LSB +: 4];
  assign runOk = ctrl_reg[CTRL_MAIN_EN] && ctrl_reg[CTRL_FULL_PWR];
  assign mainEnable = ctrl_reg[CTRL_MAIN_EN];
  assign auxEnable = ctrl_reg[CTRL_AUX_EN];
  assign biasRefEnable = ctrl_reg[CTRL_BIAS_EN];

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      syncPipe_reg <= 2'b00;
      syncPrev_reg <= 1'b0;
    end else begin
      syncPipe_reg <= {syncPipe_reg[0], syncIn};
      syncPrev_reg <= syncPipe_reg[1];
    end
  end
  logic syncRise;
  assign syncRise = syncPipe_reg[1] && !syncPrev_reg;

  // ************************************************************
  // sequencer
  // ************************************************************
  mrr_state_t state_reg;
  logic [7:0] cyc_reg;
  logic [4:0] slot_reg;
  logic [2:0] pin_reg;
  logic slotDone;
  logic startRun;
  assign startRun = runOk && (state_reg == MRR_IDLE);
  assign slotDone = (state_reg == MRR_RUN) && (cyc_reg == 8'(SLOT_CYC - 1));

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= MRR_IDLE;
    end else begin
      case (state_reg)
        MRR_IDLE: begin
          if (runOk) begin
            state_reg <= MRR_RUN;
          end
        end
        MRR_RUN: begin
          if (!runOk) begin
            state_reg <= MRR_IDLE;
          end
        end
        default: begin
          state_reg <= MRR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cyc_reg <= 8'h00;
      slot_reg <= SLOT_DIE;
    end else if (state_reg != MRR_RUN || !runOk || syncRise) begin
      cyc_reg <= 8'h00;
      slot_reg <= SLOT_DIE;
    end else if (slotDone) begin
      cyc_reg <= 8'h00;
      slot_reg <= (slot_reg == SLOT_LAST) ? SLOT_DIE : slot_reg + 5'h01;
    end else begin
      cyc_reg <= cyc_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pin_reg <= 3'h0;
    end else if (startRun) begin
      pin_reg <= 3'h0;
    end else if (slotDone && slot_reg == SLOT_LAST) begin
      pin_reg <= pin_reg + 3'h1;
    end
  end

  assign muxSel = slot_reg;
  assign pinSel = pin_reg;
  assign convStart = (state_reg == MRR_RUN) && runOk && (cyc_reg == 8'h00);

  // ************************************************************
  // result mapping
  // ************************************************************
  logic isCell;
  logic cellActive;
  logic [4:0] cellNum;
  logic measValid;
  logic [4:0] resIdx;
  assign isCell = slot_reg >= SLOT_CELL0 && slot_reg < SLOT_BAR;
  assign cellNum = slot_reg - SLOT_CELL0;
  assign cellActive = cellNum <= {1'b0, topActive};
  always_comb begin
    measValid = 1'b0;
    resIdx = slot_reg;
    if (slot_reg <= SLOT_BAR) begin
      measValid = !isCell || cellActive;
    end else if (slot_reg == SLOT_PIN) begin
      measValid = 1'b1;
      resIdx = RES_PIN0 + {2'b00, pin_reg};
    end
  end

  // ************************************************************
  // result pairs
  // ************************************************************
  logic [15:0] resHi_reg [NUM_RES];
  logic [7:0] resLo_reg [NUM_RES];
  logic [NUM_RES-1:0] loHold_reg;
  logic [7:0] rdIdx;
  assign rdIdx = regAddr - REG_RES_BASE;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_RES; gi++) begin : g_res
      logic hiRd;
      logic loRd;
      logic wrEn;
      assign hiRd = regRd && rdIdx == 8'(2 * gi);
      assign loRd = regRd && rdIdx == 8'(2 * gi + 1);
      assign wrEn = slotDone && measValid && resIdx == 5'(gi);
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          loHold_reg[gi] <= 1'b0;
        end else if (startRun) begin
          loHold_reg[gi] <= 1'b0;
        end else if (hiRd) begin
          loHold_reg[gi] <= 1'b1;
        end else if (loRd) begin
          loHold_reg[gi] <= 1'b0;
        end
      end
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          resHi_reg[gi] <= RESULT_PRESET;
        end else if (startRun) begin
          resHi_reg[gi] <= RESULT_PRESET;
        end else if (wrEn) begin
          resHi_reg[gi] <= adcSample;
        end
      end
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          resLo_reg[gi] <= RESULT_PRESET[7:0];
        end else if (startRun) begin
          resLo_reg[gi] <= RESULT_PRESET[7:0];
        end else if (wrEn && !loHold_reg[gi]) begin
          resLo_reg[gi] <= adcSample[7:0];
        end
      end
    end
  endgenerate

  // ************************************************************
  // read port
  // ************************************************************
  logic [7:0] rdNext;
  always_comb begin
    rdNext = 8'h00;
    if (regAddr == REG_CTRL) begin
      rdNext = ctrl_reg;
    end else if (regAddr == REG_STATUS) begin
      rdNext = {state_reg == MRR_RUN, pin_reg, 4'h0};
    end else if (regAddr >= REG_RES_BASE && rdIdx < 8'(2 * NUM_RES)) begin
      rdNext = rdIdx[0] ? resLo_reg[rdIdx[5:1]] : resHi_reg[rdIdx[5:1]][15:8];
    end
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      regRdata <= rdNext;
    end else begin
      regRdata <= 8'h00;
    end
  end

  // ************************************************************
  // check helpers
  // ************************************************************
  // pass length counter, read by checks only
  logic [11:0] passCyc_reg;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      passCyc_reg <= 12'h000;
    end else if (state_reg != MRR_RUN || !runOk || syncRise) begin
      passCyc_reg <= 12'h000;
    end else if (slotDone && slot_reg == SLOT_LAST) begin
      passCyc_reg <= 12'h000;
    end else begin
      passCyc_reg <= passCyc_reg + 12'h001;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  property p_slot_wrap;
    @(posedge clk_sys) disable iff (sys_rst)
      (slotDone && slot_reg == SLOT_LAST && runOk && !syncRise) |=> slot_reg == SLOT_DIE;
  endproperty
  a_slot_wrap: assert property (p_slot_wrap) else $error("slot did not wrap");

  property p_slot_len;
    @(posedge clk_sys) disable iff (sys_rst)
      (state_reg == MRR_RUN && runOk && !syncRise && cyc_reg != 8'(SLOT_CYC - 1)) |=>
        (cyc_reg == $past(cyc_reg) + 8'h01 && slot_reg == $past(slot_reg));
  endproperty
  a_slot_len: assert property (p_slot_len) else $error("slot length wrong");

  property p_preset;
    @(posedge clk_sys) disable iff (sys_rst)
      startRun |=> resHi_reg[0] == RESULT_PRESET;
  endproperty
  a_preset: assert property (p_preset) else $error("preset missing");

  property p_idle_off;
    @(posedge clk_sys) disable iff (sys_rst)
      !ctrl_reg[CTRL_FULL_PWR] |=> !convStart;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("conversion outside full power");

  property p_pass_len;
    @(posedge clk_sys) disable iff (sys_rst)
      (slotDone && slot_reg == SLOT_LAST) |-> passCyc_reg == 12'(NUM_SLOTS * SLOT_CYC - 1);
  endproperty
  a_pass_len: assert property (p_pass_len) else $error("pass length wrong");

  property p_slot_range;
    @(posedge clk_sys) disable iff (sys_rst)
      slot_reg <= SLOT_LAST;
  endproperty
  a_slot_range: assert property (p_slot_range) else $error("slot out of range");

  property p_pin_rotate;
    @(posedge clk_sys) disable iff (sys_rst)
      (slotDone && slot_reg == SLOT_LAST) |=> pinSel == $past(pin_reg) + 3'h1;
  endproperty
  a_pin_rotate: assert property (p_pin_rotate) else $error("pin input did not rotate");

  property p_pin_start;
    @(posedge clk_sys) disable iff (sys_rst)
      startRun |=> pinSel == 3'h0;
  endproperty
  a_pin_start: assert property (p_pin_start) else $error("pin rotation not restarted");

  property p_lo_hold;
    @(posedge clk_sys) disable iff (sys_rst)
      (loHold_reg[SLOT_DIE] && !startRun && !(regRd && rdIdx == 8'h01)) |=>
        resLo_reg[SLOT_DIE] == $past(resLo_reg[SLOT_DIE]);
  endproperty
  a_lo_hold: assert property (p_lo_hold) else $error("held low byte changed");

  property p_lo_follow;
    @(posedge clk_sys) disable iff (sys_rst)
      (slotDone && slot_reg == SLOT_DIE && !loHold_reg[SLOT_DIE]) |=>
        resLo_reg[SLOT_DIE] == $past(adcSample[7:0]);
  endproperty
  a_lo_follow: assert property (p_lo_follow) else $error("low byte not refreshed");

  property p_hi_update;
    @(posedge clk_sys) disable iff (sys_rst)
      (slotDone && slot_reg == SLOT_BAR) |=> resHi_reg[SLOT_BAR] == $past(adcSample);
  endproperty
  a_hi_update: assert property (p_hi_update) else $error("bar result not written");

  property p_die_raw;
    @(posedge clk_sys) disable iff (sys_rst)
      (slotDone && slot_reg == SLOT_DIE) |=> resHi_reg[SLOT_DIE] == $past(adcSample);
  endproperty
  a_die_raw: assert property (p_die_raw) else $error("die code altered");

  property p_cell_skip;
    @(posedge clk_sys) disable iff (sys_rst)
      (slotDone && slot_reg == SLOT_BAR - 5'h01 && !cellActive) |=>
        $stable(resHi_reg[SLOT_BAR - 5'h01]);
  endproperty
  a_cell_skip: assert property (p_cell_skip) else $error("inactive cell written");

  property p_sync_restart;
    @(posedge clk_sys) disable iff (sys_rst)
      (syncRise && state_reg == MRR_RUN) |=> (slot_reg == SLOT_DIE && cyc_reg == 8'h00);
  endproperty
  a_sync_restart: assert property (p_sync_restart) else $error("sync did not restart");

  property p_preset_lo;
    @(posedge clk_sys) disable iff (sys_rst)
      startRun |=> resLo_reg[SLOT_DIE] == RESULT_PRESET[7:0];
  endproperty
  a_preset_lo: assert property (p_preset_lo) else $error("low preset missing");

  property p_ctrl_write;
    @(posedge clk_sys) disable iff (sys_rst)
      (regWr && regAddr == REG_CTRL) |=>
        (mainEnable == $past(regWdata[CTRL_MAIN_EN]) && auxEnable == $past(regWdata[CTRL_AUX_EN]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("enables not independent");

  property p_bias_only;
    @(posedge clk_sys) disable iff (sys_rst)
      !(regWr && regAddr == REG_CTRL) |=> $stable(biasRefEnable);
  endproperty
  a_bias_only: assert property (p_bias_only) else $error("bias ref changed by itself");
endmodule : mrr_main_adc
`default_nettype wire

// ### testbench/mrr_main_adc_bench.sv
/*
  Self-checking bench for the main converter round-robin sequencer.
  Assumes mrr_pkg and mrr_main_adc are compiled before this file.
*/
`default_nettype none
module mrr_main_adc_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import mrr_pkg::*;
  // ************************************************************
  // stimulus and design
  // ************************************************************
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic syncIn = 1'b0;
  logic [4:0] salt = 5'h00;
  logic [7:0] regRdata;
  logic [15:0] adcSample;
  logic [4:0] muxSel;
  logic [2:0] pinSel;
  logic convStart, mainEnable, auxEnable, biasRefEnable;
  int errors = 0;
  int comparisons = 0;
  localparam int BIAS_WAIT_CYC = 13500;
  always #50 clk_sys = ~clk_sys;
  // sample names its own slot in the high byte, salt in the low byte
  assign adcSample = {3'h5, muxSel, salt, 3'h0};
  mrr_main_adc u_mrr_main_adc (.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .syncIn(syncIn), .adcSample(adcSample), .muxSel(muxSel), .pinSel(pinSel),
    .convStart(convStart), .mainEnable(mainEnable), .auxEnable(auxEnable),
    .biasRefEnable(biasRefEnable));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic final_report;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chkByte
  task automatic chkBit(input logic got, input logic exp, input string msg);
    chkByte({7'h00, got}, {7'h00, exp}, msg);
  endtask : chkBit
  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    #1;
  endtask : wrReg
  task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rdReg
  task automatic chkPair(input int k, input logic [15:0] exp, input string msg);
    logic [7:0] d;
    rdReg(REG_RES_BASE + 8'(2 * k), d);
    chkByte(d, exp[15:8], msg);
    rdReg(REG_RES_BASE + 8'(2 * k + 1), d);
    chkByte(d, exp[7:0], msg);
  endtask : chkPair
  task automatic waitSlot(input logic [4:0] s);
    int n;
    n = 0;
    while (muxSel !== s) begin
      @(posedge clk_sys);
      #1 n++;
      if (n > 4000) begin
        errors++;
        $display("ERROR %0t slot wait timed out", $time);
        final_report();
      end
    end
  endtask : waitSlot
  function automatic logic [15:0] smp(input logic [4:0] s, input logic [4:0] t);
    return {3'h5, s, t, 3'h0};
  endfunction : smp
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic test_control;
    logic [7:0] d;
    chkBit(biasRefEnable, 1'b0, "bias ref after reset");
    wrReg(8'h05, 8'hff);
    rdReg(8'h05, d);
    chkByte(d, 8'h00, "unmapped read");
    wrReg(REG_CTRL, 8'h02);
    chkBit(auxEnable, 1'b1, "aux alone on");
    chkBit(mainEnable, 1'b0, "main stays off");
    wrReg(REG_CTRL, 8'h05);
    repeat (BIAS_WAIT_CYC) @(posedge clk_sys);
    rdReg(REG_CTRL, d);
    chkByte(d, 8'h05, "bias ref confirmed before use");
    chkBit(biasRefEnable, 1'b1, "bias ref on");
    chkBit(auxEnable, 1'b0, "aux off with main on");
    $display("test_control done");
  endtask : test_control
  task automatic test_full_power;
    logic seen;
    seen = 1'b0;
    wrReg(REG_CTRL, 8'h01);
    repeat (200) begin
      @(posedge clk_sys);
      #1 seen = seen | (convStart === 1'b1);
    end
    chkBit(seen, 1'b0, "conversion without full power");
    $display("test_full_power done");
  endtask : test_full_power
  task automatic test_sequence;
    int n;
    logic [7:0] d;
    salt <= 5'h01;
    wrReg(REG_CTRL, 8'hf9);
    chkPair(0, RESULT_PRESET, "preset on enable");
    waitSlot(5'h01);
    chkBit(convStart, 1'b1, "start at slot entry");
    n = 0;
    while (muxSel === 5'h01 && n < 200) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chkByte(8'(n), 8'(SLOT_CYC), "slot length");
    waitSlot(SLOT_LAST);
    waitSlot(5'h00);
    chkByte({3'h0, muxSel}, 8'h00, "wrap to first slot");
    chkPair(0, smp(SLOT_DIE, 5'h01), "die result");
    chkPair(1, smp(SLOT_BIAS, 5'h01), "bias result");
    chkPair(17, smp(5'h11, 5'h01), "cell 16 result");
    chkPair(18, smp(SLOT_BAR, 5'h01), "bar result");
    chkPair(19, smp(SLOT_PIN, 5'h01), "pin 1 result");
    chkPair(20, RESULT_PRESET, "pin 2 not yet");
    chkByte({5'h00, pinSel}, 8'h01, "pin rotates");
    rdReg(REG_STATUS, d);
    chkByte(d & 8'hf0, 8'h90, "status running pin");
    $display("test_sequence done");
  endtask : test_sequence
  task automatic test_freeze;
    logic [7:0] d;
    waitSlot(5'h02);
    rdReg(REG_RES_BASE, d);
    chkByte(d, 8'ha0, "die high");
    salt <= 5'h02;
    waitSlot(5'h00);
    waitSlot(5'h01);
    rdReg(REG_RES_BASE + 8'h01, d);
    chkByte(d, 8'h08, "low held after high read");
    waitSlot(5'h00);
    waitSlot(5'h01);
    chkPair(0, smp(SLOT_DIE, 5'h02), "low refreshed after low read");
    $display("test_freeze done");
  endtask : test_freeze
  task automatic test_top;
    wrReg(REG_CTRL, 8'h00);
    wrReg(REG_CTRL, 8'h29);
    chkPair(0, RESULT_PRESET, "preset on re-enable");
    waitSlot(SLOT_BAR);
    chkPair(4, smp(5'h04, 5'h02), "cell 3 measured");
    chkPair(5, RESULT_PRESET, "cell 4 skipped");
    waitSlot(5'h00);
    chkBit(convStart, 1'b1, "slot timing kept");
    $display("test_top done");
  endtask : test_top
  task automatic test_sync;
    int n;
    waitSlot(5'h08);
    syncIn <= 1'b1;
    n = 0;
    while (muxSel !== 5'h00 && n < 8) begin
      @(posedge clk_sys);
      #1 n++;
    end
    syncIn <= 1'b0;
    chkByte({3'h0, muxSel}, 8'h00, "sync restarts pass");
    $display("test_sync done");
  endtask : test_sync
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    test_control();
    test_full_power();
    test_sequence();
    test_freeze();
    test_top();
    test_sync();
    final_report();
  end
endmodule : mrr_main_adc_bench
`default_nettype wire
